// [rtl/nv_seq_pkg.sv]
package nv_seq_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_ADDRESS_HIGH = 8'hF9;
   localparam logic [7:0] IDX_ADDRESS_LOW = 8'hFA;
   localparam logic [7:0] IDX_WRITE_BYTE = 8'hFB;
   localparam logic [7:0] IDX_COMMAND_CODE = 8'hFC;
   localparam logic [7:0] IDX_ERASE_DURATION = 8'hFD;
   localparam logic [7:0] IDX_CONTROL_STATUS = 8'hF0;
   localparam int ADDR_W = 10;

   // Reset values
   localparam logic [7:0] RST_ADDRESS_HIGH = 8'h00;
   localparam logic [7:0] RST_ADDRESS_LOW = 8'h00;
   localparam logic [7:0] RST_WRITE_BYTE = 8'h00;
   localparam logic [7:0] RST_COMMAND_CODE = 8'h00;
   localparam logic [7:0] RST_ERASE_DURATION = 8'h5A;

   // Field layout
   localparam logic [7:0] ADDRESS_HIGH_MASK = 8'h07;
   localparam int AH_PAGE_BIT = 2;
   localparam int CS_ARRAY_SELECT_BIT = 0;
   localparam int CS_BUSY_BIT = 1;
   localparam int ERASE_SETTING_W = 5;
   localparam logic [4:0] ERASE_SETTING_MAX = 5'h09;

   // Command codes
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h96;
   localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h69;

   // Main data area base
   localparam logic [13:0] MAIN_AREA_BASE = 14'h3C00;

   // Timing, times in ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS = 23500;
   localparam int MAIN_STEP_NS = 1000000;
   localparam int MAIN_EXTRA_NS = 130000;
   localparam int INFO_STEP_NS = 500000;
   localparam int INFO_EXTRA_NS = 65000;
   localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAIN_STEP_CYC = (MAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAIN_EXTRA_CYC = (MAIN_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INFO_STEP_CYC = (INFO_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INFO_EXTRA_CYC = (INFO_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 20;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG = 2'b10
   } nv_state_type;
endpackage

// [rtl/nv_erase_time_calc.sv]
module nv_erase_time_calc #(
   parameter int MAIN_STEP = nv_seq_pkg::MAIN_STEP_CYC,
   parameter int MAIN_EXTRA = nv_seq_pkg::MAIN_EXTRA_CYC,
   parameter int INFO_STEP = nv_seq_pkg::INFO_STEP_CYC,
   parameter int INFO_EXTRA = nv_seq_pkg::INFO_EXTRA_CYC
) (
   // Setting
   input wire logic [nv_seq_pkg::ERASE_SETTING_W-1:0] i_setting,
   input wire logic i_info_page,
   // Result
   output logic [nv_seq_pkg::CNT_W-1:0] o_cycles
);
   // Settings above nine behave as nine
   function automatic int steps(input logic [4:0] s);
      logic [4:0] c;
      c = (s > nv_seq_pkg::ERASE_SETTING_MAX) ? nv_seq_pkg::ERASE_SETTING_MAX : s;
      return int'(c) + 1;
   endfunction

   int total;

   always_comb begin
      if (i_info_page) begin
         total = steps(i_setting) * INFO_STEP + INFO_EXTRA; // [R09]
      end else begin
         total = steps(i_setting) * MAIN_STEP + MAIN_EXTRA; // [R08]
      end
      o_cycles = total[nv_seq_pkg::CNT_W-1:0];
   end
endmodule

// [rtl/nv_op_timer.sv]
module nv_op_timer (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_load,
   input wire logic [nv_seq_pkg::CNT_W-1:0] i_load_value,
   // Status
   output logic o_done
);
   logic [nv_seq_pkg::CNT_W-1:0] count_q;
   logic [nv_seq_pkg::CNT_W-1:0] count_d;

   // Done in the last cycle of a run of exactly i_load_value cycles
   always_comb begin
      count_d = count_q;
      if (i_load) begin
         count_d = i_load_value;
      end else if (count_q != '0) begin
         count_d = count_q - 1'b1;
      end
      o_done = (count_q == {{(nv_seq_pkg::CNT_W-1){1'b0}}, 1'b1});
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// [rtl/self_program_nv_sequencer.sv]
// What this block does
// R01: With array_select 0, software keeps address high bit 2 at zero.
// R02: Main area target is high bits 1:0 above the eight low bits.
// R03: With array_select 1, high bit 2 picks info_page_a or info_page_b.
// R04: Info page offset is high bit 0 above the eight low bits.
// R05: Command 0x96 erases the page holding the addressed location.
// R06: Command 0x69 programs the data byte into the addressed location.
// R07: Byte program always lasts 23.5 us, timing bits 7:5 ignored.
// R08: Main area erase lasts (N+1) ms plus 0.13 ms, N clamped at 9.
// R09: Info page erase lasts (N+1)*0.5 ms plus 0.065 ms, N clamped at 9.
// R10: Software never writes reserved registers or reserved bits.
// R11: Bus accesses stall until the running operation has finished.
// R12: Any other command code starts nothing.
//
// Design decision made here: the Avalon-MM register port.
module self_program_nv_sequencer #(
   parameter int MAIN_STEP = nv_seq_pkg::MAIN_STEP_CYC,
   parameter int MAIN_EXTRA = nv_seq_pkg::MAIN_EXTRA_CYC,
   parameter int INFO_STEP = nv_seq_pkg::INFO_STEP_CYC,
   parameter int INFO_EXTRA = nv_seq_pkg::INFO_EXTRA_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [nv_seq_pkg::ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Nonvolatile array control
   output logic o_nv_erase,
   output logic o_nv_program,
   output logic o_nv_array_select,
   output logic o_nv_info_page_b,
   output logic [13:0] o_nv_addr,
   output logic [7:0] o_nv_wdata,
   output logic o_nv_busy
);
   function automatic logic reg_hit(input logic [nv_seq_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
      return a == {idx, 2'b00};
   endfunction

   logic [7:0] addr_high_q, addr_high_d;
   logic [7:0] addr_low_q, addr_low_d;
   logic [7:0] write_byte_q, write_byte_d;
   logic [7:0] command_q, command_d;
   logic [7:0] erase_dur_q, erase_dur_d;
   logic array_sel_q, array_sel_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d;
   nv_seq_pkg::nv_state_type state_q, state_d;
   logic erase_q, erase_d;
   logic prog_q, prog_d;
   logic busy_q, busy_d;
   logic page_b_q, page_b_d;
   logic nv_sel_q, nv_sel_d;
   logic [13:0] nv_addr_q, nv_addr_d;
   logic [7:0] nv_wdata_q, nv_wdata_d;
   logic req;
   logic accept;
   logic wr_lane0;
   logic start_erase;
   logic start_prog;
   logic timer_load;
   logic timer_done;
   logic [nv_seq_pkg::CNT_W-1:0] erase_cycles;
   logic [nv_seq_pkg::CNT_W-1:0] load_value;
   logic [31:0] read_mux;

   nv_erase_time_calc #(
      .MAIN_STEP(MAIN_STEP),
      .MAIN_EXTRA(MAIN_EXTRA),
      .INFO_STEP(INFO_STEP),
      .INFO_EXTRA(INFO_EXTRA)
   ) u_erase_time (
      .i_setting(erase_dur_q[nv_seq_pkg::ERASE_SETTING_W-1:0]),
      .i_info_page(array_sel_q),
      .o_cycles(erase_cycles)
   );

   nv_op_timer u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(timer_load),
      .i_load_value(load_value),
      .o_done(timer_done)
   );

   // Bus handshake and register file
   always_comb begin
      req = i_read | i_write;
      accept = req & ~wait_q;
      wr_lane0 = accept & i_write & i_byteenable[0];
      read_mux = 32'h0000_0000;
      if (reg_hit(i_address, nv_seq_pkg::IDX_ADDRESS_HIGH)) begin
         read_mux = {24'h00_0000, addr_high_q};
      end else if (reg_hit(i_address, nv_seq_pkg::IDX_ADDRESS_LOW)) begin
         read_mux = {24'h00_0000, addr_low_q};
      end else if (reg_hit(i_address, nv_seq_pkg::IDX_WRITE_BYTE)) begin
         read_mux = {24'h00_0000, write_byte_q};
      end else if (reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE)) begin
         read_mux = {24'h00_0000, command_q};
      end else if (reg_hit(i_address, nv_seq_pkg::IDX_ERASE_DURATION)) begin
         read_mux = {24'h00_0000, erase_dur_q};
      end else if (reg_hit(i_address, nv_seq_pkg::IDX_CONTROL_STATUS)) begin
         read_mux[nv_seq_pkg::CS_ARRAY_SELECT_BIT] = array_sel_q;
         read_mux[nv_seq_pkg::CS_BUSY_BIT] = busy_q;
      end
      wait_d = 1'b1;
      rdata_d = rdata_q;
      // No answer is prepared while an operation runs
      if (req & wait_q & ~busy_q) begin // [R11]
         wait_d = 1'b0;
         rdata_d = i_read ? read_mux : 32'h0000_0000;
      end
      addr_high_d = addr_high_q;
      addr_low_d = addr_low_q;
      write_byte_d = write_byte_q;
      command_d = command_q;
      erase_dur_d = erase_dur_q;
      array_sel_d = array_sel_q;
      if (wr_lane0) begin
         if (reg_hit(i_address, nv_seq_pkg::IDX_ADDRESS_HIGH)) begin
            addr_high_d = i_writedata[7:0] & nv_seq_pkg::ADDRESS_HIGH_MASK;
         end
         if (reg_hit(i_address, nv_seq_pkg::IDX_ADDRESS_LOW)) begin
            addr_low_d = i_writedata[7:0];
         end
         if (reg_hit(i_address, nv_seq_pkg::IDX_WRITE_BYTE)) begin
            write_byte_d = i_writedata[7:0];
         end
         if (reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE)) begin
            command_d = i_writedata[7:0];
         end
         if (reg_hit(i_address, nv_seq_pkg::IDX_ERASE_DURATION)) begin
            erase_dur_d = i_writedata[7:0];
         end
         if (reg_hit(i_address, nv_seq_pkg::IDX_CONTROL_STATUS)) begin
            array_sel_d = i_writedata[nv_seq_pkg::CS_ARRAY_SELECT_BIT];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         addr_high_q <= nv_seq_pkg::RST_ADDRESS_HIGH;
         addr_low_q <= nv_seq_pkg::RST_ADDRESS_LOW;
         write_byte_q <= nv_seq_pkg::RST_WRITE_BYTE;
         command_q <= nv_seq_pkg::RST_COMMAND_CODE;
         erase_dur_q <= nv_seq_pkg::RST_ERASE_DURATION;
         array_sel_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         wait_q <= 1'b1;
      end else begin
         addr_high_q <= addr_high_d;
         addr_low_q <= addr_low_d;
         write_byte_q <= write_byte_d;
         command_q <= command_d;
         erase_dur_q <= erase_dur_d;
         array_sel_q <= array_sel_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
      end
   end

   // Operation sequencer
   always_comb begin
      start_erase = wr_lane0 & reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE)
                    & (i_writedata[7:0] == nv_seq_pkg::CMD_PAGE_ERASE); // [R05] [R12]
      start_prog = wr_lane0 & reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE)
                   & (i_writedata[7:0] == nv_seq_pkg::CMD_BYTE_PROGRAM); // [R06] [R12]
      timer_load = (start_erase | start_prog) & (state_q == nv_seq_pkg::ST_IDLE);
      // Program time ignores the timing register
      load_value = start_prog ? nv_seq_pkg::CNT_W'(nv_seq_pkg::PROG_CYC) : erase_cycles; // [R07]
      state_d = state_q;
      erase_d = 1'b0;
      prog_d = 1'b0;
      nv_sel_d = nv_sel_q;
      page_b_d = page_b_q;
      nv_addr_d = nv_addr_q;
      nv_wdata_d = nv_wdata_q;
      case (state_q)
         nv_seq_pkg::ST_IDLE: begin
            if (timer_load) begin
               state_d = start_prog ? nv_seq_pkg::ST_PROG : nv_seq_pkg::ST_ERASE;
               erase_d = start_erase;
               prog_d = start_prog;
               nv_sel_d = array_sel_q;
               page_b_d = array_sel_q & addr_high_q[nv_seq_pkg::AH_PAGE_BIT]; // [R03]
               if (array_sel_q) begin
                  nv_addr_d = {5'h00, addr_high_q[0], addr_low_q}; // [R04]
               end else begin
                  nv_addr_d = nv_seq_pkg::MAIN_AREA_BASE | {4'h0, addr_high_q[1:0], addr_low_q}; // [R02]
               end
               nv_wdata_d = write_byte_q;
            end
         end
         nv_seq_pkg::ST_ERASE, nv_seq_pkg::ST_PROG: begin
            if (timer_done) begin
               state_d = nv_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = nv_seq_pkg::ST_IDLE;
         end
      endcase
      busy_d = (state_d != nv_seq_pkg::ST_IDLE);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= nv_seq_pkg::ST_IDLE;
         erase_q <= 1'b0;
         prog_q <= 1'b0;
         busy_q <= 1'b0;
         nv_sel_q <= 1'b0;
         page_b_q <= 1'b0;
         nv_addr_q <= 14'h0000;
         nv_wdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         erase_q <= erase_d;
         prog_q <= prog_d;
         busy_q <= busy_d;
         nv_sel_q <= nv_sel_d;
         page_b_q <= page_b_d;
         nv_addr_q <= nv_addr_d;
         nv_wdata_q <= nv_wdata_d;
      end
   end

   assign o_readdata = rdata_q;
   assign o_waitrequest = wait_q;
   assign o_nv_erase = erase_q;
   assign o_nv_program = prog_q;
   assign o_nv_array_select = nv_sel_q;
   assign o_nv_info_page_b = page_b_q;
   assign o_nv_addr = nv_addr_q;
   assign o_nv_wdata = nv_wdata_q;
   assign o_nv_busy = busy_q;

   // Helper logic for the checks: run length and expected length
   logic [nv_seq_pkg::CNT_W:0] run_len_q;
   logic [nv_seq_pkg::CNT_W-1:0] expect_len_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_len_q <= '0;
         expect_len_q <= '0;
      end else begin
         run_len_q <= busy_q ? run_len_q + 1'b1 : '0;
         if (timer_load) begin
            expect_len_q <= load_value;
         end
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_cmd_write(logic [7:0] code);
      accept && i_write && i_byteenable[0] && reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE)
         && i_writedata[7:0] == code && !busy_q;
   endsequence

   sequence s_handshake;
      req && wait_q && !busy_q ##1 !wait_q ##1 wait_q;
   endsequence

   a_erase_start: assert property (s_cmd_write(nv_seq_pkg::CMD_PAGE_ERASE) |=> // [R05]
      o_nv_erase && !o_nv_program && o_nv_busy ##1 !o_nv_erase && o_nv_busy)
      else $error("erase command did not start one erase");
   a_prog_start: assert property (s_cmd_write(nv_seq_pkg::CMD_BYTE_PROGRAM) |=> // [R06]
      o_nv_program && !o_nv_erase && o_nv_wdata == $past(write_byte_q))
      else $error("program command did not start with the data byte");
   a_bad_command: assert property (accept && i_write && reg_hit(i_address, nv_seq_pkg::IDX_COMMAND_CODE) // [R12]
      && i_writedata[7:0] != nv_seq_pkg::CMD_PAGE_ERASE && i_writedata[7:0] != nv_seq_pkg::CMD_BYTE_PROGRAM
      && !busy_q |=> !o_nv_busy && !o_nv_erase && !o_nv_program)
      else $error("unknown command started an operation");
   a_main_addr: assert property ((o_nv_erase || o_nv_program) && !o_nv_array_select |-> // [R02]
      o_nv_addr == (nv_seq_pkg::MAIN_AREA_BASE | {4'h0, addr_high_q[1:0], addr_low_q}) && !o_nv_info_page_b)
      else $error("main area address formed wrongly");
   a_info_addr: assert property ((o_nv_erase || o_nv_program) && o_nv_array_select |-> // [R04]
      o_nv_addr == {5'h00, addr_high_q[0], addr_low_q})
      else $error("info page offset formed wrongly");
   a_info_page: assert property ((o_nv_erase || o_nv_program) && o_nv_array_select |-> // [R03]
      o_nv_info_page_b == addr_high_q[nv_seq_pkg::AH_PAGE_BIT])
      else $error("info page choice wrong");
   a_stall_busy: assert property (o_nv_busy && req |=> o_waitrequest) // [R11]
      else $error("access answered while busy");
   a_bus_answer: assert property (req && wait_q && !busy_q |-> s_handshake) // [R11]
      else $error("idle access not answered in one cycle");
   a_prog_length: assert property ($fell(o_nv_busy) && $past(state_q) == nv_seq_pkg::ST_PROG |-> // [R07]
      run_len_q == (nv_seq_pkg::CNT_W + 1)'(nv_seq_pkg::PROG_CYC))
      else $error("program length wrong");
   a_erase_length: assert property ($fell(o_nv_busy) && $past(state_q) == nv_seq_pkg::ST_ERASE |-> // [R08] [R09]
      run_len_q == {1'b0, expect_len_q})
      else $error("erase length wrong");
endmodule

// [test/self_program_nv_sequencer_bench.sv]
module self_program_nv_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // Shortened erase steps keep the run brief; byte program stays at its fixed length
   localparam int MS = 10;
   localparam int ME = 3;
   localparam int IS = 5;
   localparam int IE = 2;
   localparam int PROG_L = 2350;

   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [9:0] i_address = 10'h000;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0000_0000;
   logic [3:0] i_byteenable = 4'hF;
   logic [31:0] o_readdata;
   logic o_waitrequest, o_nv_erase, o_nv_program, o_nv_array_select, o_nv_info_page_b, o_nv_busy;
   logic [13:0] o_nv_addr;
   logic [7:0] o_nv_wdata;
   int n_mismatch = 0;
   int checked = 0;
   int n_erase = 0;
   int n_prog = 0;
   int busy_tot = 0;
   int cycles = 0;
   logic [13:0] cap_addr;
   logic [7:0] cap_wdata;
   logic cap_sel, cap_pageb;
   logic [31:0] rd;
   logic [7:0] nv [4] = '{8'h00, 8'h09, 8'h0A, 8'hFF};
   logic [7:0] bad [4] = '{8'h00, 8'h5A, 8'h97, 8'h68};

   always #5 i_clk = ~i_clk;

   self_program_nv_sequencer #(.MAIN_STEP(MS), .MAIN_EXTRA(ME), .INFO_STEP(IS), .INFO_EXTRA(IE)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_nv_erase(o_nv_erase), .o_nv_program(o_nv_program),
      .o_nv_array_select(o_nv_array_select), .o_nv_info_page_b(o_nv_info_page_b),
      .o_nv_addr(o_nv_addr), .o_nv_wdata(o_nv_wdata), .o_nv_busy(o_nv_busy));

   task automatic end_sim;
      $display("Counts: %0d mismatches in %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Counts start pulses and busy cycles, and captures the array controls at each start
   always @(posedge i_clk) begin
      cycles++;
      if (o_nv_program === 1'b1) n_prog++;
      if (o_nv_erase === 1'b1) n_erase++;
      if (o_nv_busy === 1'b1) busy_tot++;
      if (o_nv_erase === 1'b1 || o_nv_program === 1'b1) begin
         cap_addr = o_nv_addr;
         cap_wdata = o_nv_wdata;
         cap_sel = o_nv_array_select;
         cap_pageb = o_nv_info_page_b;
      end
      if (cycles == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus_acc(input logic wr_en, input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be);
      int n;
      @(posedge i_clk);
      i_address <= {idx, 2'b00};
      i_write <= wr_en;
      i_read <= ~wr_en;
      i_writedata <= {24'h000000, data};
      i_byteenable <= be;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 25000);
      // An access that is never answered counts as a failure
      if (n >= 25000) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 1'b1, 1'b0);
      end
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      bus_acc(1'b1, idx, data, 4'h1);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      bus_acc(1'b0, idx, 8'h00, 4'hF);
      chk(rd, {24'h000000, exp});
   endtask

   // Issues a command, then a status read that stalls until the operation ends
   task automatic do_op(input logic [7:0] cmd, input int len, input logic [13:0] addr, input logic sel,
                        input logic pb, input logic [7:0] wdat);
      int se, sp, sb;
      se = n_erase;
      sp = n_prog;
      sb = busy_tot;
      wr(nv_seq_pkg::IDX_COMMAND_CODE, cmd);
      rd_chk(nv_seq_pkg::IDX_CONTROL_STATUS, {7'h00, sel});
      chk(busy_tot - sb, len);
      chk(n_prog - sp, cmd == nv_seq_pkg::CMD_BYTE_PROGRAM);
      chk(n_erase - se, cmd == nv_seq_pkg::CMD_PAGE_ERASE);
      if (len != 0) begin
         chk(cap_addr, addr);
         chk(cap_wdata, wdat);
         chk(cap_sel, sel);
         chk(cap_pageb, pb);
      end
      rd_chk(nv_seq_pkg::IDX_COMMAND_CODE, cmd);
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      rd_chk(nv_seq_pkg::IDX_ADDRESS_HIGH, nv_seq_pkg::RST_ADDRESS_HIGH);
      rd_chk(nv_seq_pkg::IDX_ADDRESS_LOW, nv_seq_pkg::RST_ADDRESS_LOW);
      rd_chk(nv_seq_pkg::IDX_WRITE_BYTE, nv_seq_pkg::RST_WRITE_BYTE);
      rd_chk(nv_seq_pkg::IDX_COMMAND_CODE, nv_seq_pkg::RST_COMMAND_CODE);
      rd_chk(nv_seq_pkg::IDX_ERASE_DURATION, nv_seq_pkg::RST_ERASE_DURATION);
      rd_chk(nv_seq_pkg::IDX_CONTROL_STATUS, 8'h00);
      rd_chk(8'hF2, 8'h00);
      // Byte lane 0 disabled: the data register keeps its value
      wr(nv_seq_pkg::IDX_WRITE_BYTE, 8'hA5);
      bus_acc(1'b1, nv_seq_pkg::IDX_WRITE_BYTE, 8'h3C, 4'h0);
      rd_chk(nv_seq_pkg::IDX_WRITE_BYTE, 8'hA5);
      wr(nv_seq_pkg::IDX_ADDRESS_HIGH, 8'h03);
      wr(nv_seq_pkg::IDX_ADDRESS_LOW, 8'h34);
      wr(nv_seq_pkg::IDX_ERASE_DURATION, 8'hFF);
      rd_chk(nv_seq_pkg::IDX_ADDRESS_HIGH, 8'h03);
      rd_chk(nv_seq_pkg::IDX_ADDRESS_LOW, 8'h34);
      rd_chk(nv_seq_pkg::IDX_ERASE_DURATION, 8'hFF);
      do_op(nv_seq_pkg::CMD_BYTE_PROGRAM, PROG_L, 14'h3F34, 1'b0, 1'b0, 8'hA5);
      foreach (nv[i]) begin
         wr(nv_seq_pkg::IDX_ERASE_DURATION, nv[i]);
         do_op(nv_seq_pkg::CMD_PAGE_ERASE, ((nv[i][4:0] > 9 ? 9 : nv[i][4:0]) + 1) * MS + ME,
               14'h3F34, 1'b0, 1'b0, 8'hA5);
      end
      foreach (bad[i]) begin
         do_op(bad[i], 0, 14'h0000, 1'b0, 1'b0, 8'h00);
      end
      wr(nv_seq_pkg::IDX_CONTROL_STATUS, 8'h01);
      wr(nv_seq_pkg::IDX_ADDRESS_HIGH, 8'h05);
      wr(nv_seq_pkg::IDX_ADDRESS_LOW, 8'h12);
      wr(nv_seq_pkg::IDX_ERASE_DURATION, 8'h03);
      do_op(nv_seq_pkg::CMD_PAGE_ERASE, 4 * IS + IE, 14'h0112, 1'b1, 1'b1, 8'hA5);
      wr(nv_seq_pkg::IDX_ERASE_DURATION, 8'h0C);
      do_op(nv_seq_pkg::CMD_PAGE_ERASE, 10 * IS + IE, 14'h0112, 1'b1, 1'b1, 8'hA5);
      wr(nv_seq_pkg::IDX_ADDRESS_HIGH, 8'h00);
      wr(nv_seq_pkg::IDX_ADDRESS_LOW, 8'hFF);
      wr(nv_seq_pkg::IDX_WRITE_BYTE, 8'h5E);
      do_op(nv_seq_pkg::CMD_BYTE_PROGRAM, PROG_L, 14'h00FF, 1'b1, 1'b0, 8'h5E);
      // Reset in the middle of a program clears busy and returns the registers to their reset values
      wr(nv_seq_pkg::IDX_COMMAND_CODE, nv_seq_pkg::CMD_BYTE_PROGRAM);
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      chk(o_nv_busy, 1'b0);
      rd_chk(nv_seq_pkg::IDX_ERASE_DURATION, nv_seq_pkg::RST_ERASE_DURATION);
      rd_chk(nv_seq_pkg::IDX_CONTROL_STATUS, 8'h00);
      end_sim();
   end
endmodule
